// ---- include/ndef_mapper_map.svh ----
`ifndef NDEF_MAPPER_MAP_SVH
`define NDEF_MAPPER_MAP_SVH

// register byte offsets, low eight bits of haddr
`define REG_SELECT 8'h00
`define REG_FILE_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_STATUS 8'h0C

// selection codes written to the select register
`define SEL_CODE_NONE 2'h0
`define SEL_CODE_APP 2'h1
`define SEL_CODE_CC 2'h2
`define SEL_CODE_NDEF 2'h3

// physical layout
`define CC_PHYS_BASE 9'h180
`define CC_FILE_SIZE 16'h0010
`define LEN_FIELD_PHYS_BASE 9'h00C
`define GAP_FIRST 9'h00E
`define GAP_LAST 9'h00F
`define MSG_FILE_ADDR 16'h0002
`define MSG_PHYS_BASE 9'h010
`define NDEF_FILE_SIZE 16'h0172

// capability file field offsets and expected values
`define CC_LEN_OFS 16'h0000
`define CC_VERSION_OFS 16'h0002
`define CC_MAX_READ_OFS 16'h0003
`define CC_MLC_OFS 16'h0005
`define CC_TLV_T_OFS 16'h0007
`define CC_TLV_L_OFS 16'h0008
`define CC_TLV_V_OFS 16'h0009
`define CC_FID_LO_OFS 16'h000A
`define CC_VERSION_VALUE 8'h20
`define NDEF_FILE_ID 16'h0103

// status word bits
`define ST_ERR_BIT 0
`define ST_VER_OK_BIT 1
`define ST_FID_OK_BIT 2
`define ST_APP_BIT 3

// reset values
`define RESET_FILE_ADDR 16'h0000
`define RESET_WORD 32'h0000_0000
`define RESP_OKAY 1'b0

`endif

// ---- include/ndef_mapper_pkg.sv ----
package ndef_mapper_pkg;
    localparam int PHYS_W = 9;

    typedef enum logic [1:0] {SEL_NONE, SEL_APP, SEL_CC, SEL_NDEF} select_e;
    typedef enum logic [1:0] {BUS_IDLE, BUS_READ_MEM, BUS_READ_OUT} bus_state_e;

    typedef struct packed {
        logic inRange;
        logic [PHYS_W-1:0] phys;
    } map_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] offset;
    } phase_s;
endpackage

// ---- logic/nvm_byte_store.sv ----
`timescale 1ns/1ps
module nvm_byte_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 512,
    parameter int AW = $clog2(DEPTH)
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // access port
    input wire logic writeEn,
    input wire logic readEn,
    input wire logic [AW-1:0] addr,
    input wire logic [WIDTH-1:0] writeData,
    output logic [WIDTH-1:0] readData
);
    logic [WIDTH-1:0] cells [DEPTH];

    always_ff @(posedge clk) begin
        if (writeEn) begin
            cells[addr] <= writeData;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readData <= '0;
        end else if (readEn) begin
            readData <= cells[addr];
        end
    end
endmodule // nvm_byte_store

// ---- logic/ndef_file_address_mapper.sv ----
`timescale 1ns/1ps
`include "ndef_mapper_map.svh"

// Notes on behaviour
// R01 - reader selects application, then a file; mapping only applies once a file is selected
// R02 - capability file address zero is physical 0x0180, block 24, linear onward
// R03 - message file addresses zero and one map to physical 0x000C and 0x000D
// R04 - message file address 0x0002 onward maps to 0x0010 onward, skipping 0x000E-0x000F
// R05 - the message length field is always exactly two bytes
// R06 - one access run may cover length, message, or both across the gap
// R07 - writer puts mapping version 0x20 at capability file address 0x0002
// R08 - writer puts file identifier 0x0103 at capability file addresses 0x0009-0x000A
// R09 - capability file holds length, version, read and write limits, control TLV fields
// R10 - an empty message file is length 0x0003 followed by bytes 0xD00000
// R11 - there is no interrupt request output and no interrupt logic
// R12 - message file lives in tail of block 0 and blocks 1-23, capability in 24
// R13 - accesses past the selected file's end are refused and flag an error
module ndef_file_address_mapper
    import ndef_mapper_pkg::*;
#(
    parameter int DEPTH = 512
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp
);
    function automatic map_s mapFile(input select_e sel, input logic [15:0] fa);
        map_s m;
        logic [15:0] msgOfs;
        m = '0;
        msgOfs = fa - `MSG_FILE_ADDR;
        case (sel)
            SEL_CC: begin
                m.inRange = fa < `CC_FILE_SIZE; // [R12] [R13]
                m.phys = `CC_PHYS_BASE + fa[PHYS_W-1:0]; // [R02]
            end
            SEL_NDEF: begin
                m.inRange = fa < `NDEF_FILE_SIZE; // [R12] [R13]
                if (fa < `MSG_FILE_ADDR) begin
                    m.phys = `LEN_FIELD_PHYS_BASE + fa[PHYS_W-1:0]; // [R03] [R05]
                end else begin
                    m.phys = `MSG_PHYS_BASE + msgOfs[PHYS_W-1:0]; // [R04]
                end
            end
            default: begin
                m.inRange = 1'b0;
                m.phys = '0;
            end
        endcase
        return m;
    endfunction

    function automatic logic [1:0] selToCode(input select_e sel);
        case (sel)
            SEL_APP: return `SEL_CODE_APP;
            SEL_CC: return `SEL_CODE_CC;
            SEL_NDEF: return `SEL_CODE_NDEF;
            default: return `SEL_CODE_NONE;
        endcase
    endfunction

    bus_state_e state_reg, state_next;
    phase_s phase_reg, phase_next;
    select_e sel_reg, sel_next;
    logic [15:0] fileAddr_reg, fileAddr_next;
    logic err_reg, err_next;
    logic verOk_reg, fidHi_reg, fidLo_reg;
    logic [7:0] memRdata;

    wire takeXfer = hsel && htrans[1] && hready;
    wire phase_s takenPhase = '{valid: 1'b1, write: hwrite, offset: haddr[7:0]};
    wire wrPhase = phase_reg.valid && phase_reg.write && state_reg == BUS_IDLE;
    wire rdMemPhase = phase_reg.valid && !phase_reg.write && state_reg == BUS_READ_MEM;
    wire wrSelect = wrPhase && phase_reg.offset == `REG_SELECT;
    wire wrFileAddr = wrPhase && phase_reg.offset == `REG_FILE_ADDR;
    wire wrStatus = wrPhase && phase_reg.offset == `REG_STATUS;
    wire wrData = wrPhase && phase_reg.offset == `REG_DATA;
    wire rdData = rdMemPhase && phase_reg.offset == `REG_DATA;
    wire dataAccess = wrData || rdData;
    wire [1:0] selCode = hwdata[1:0];
    wire fileCode = selCode == `SEL_CODE_CC || selCode == `SEL_CODE_NDEF;
    wire selRefused = wrSelect && fileCode && sel_reg == SEL_NONE;
    wire map_s curMap = mapFile(sel_reg, fileAddr_reg);
    wire memWe = wrData && curMap.inRange;
    wire memRe = rdData && curMap.inRange;
    wire memAccess = memWe || memRe;
    wire [PHYS_W-1:0] memAddr = curMap.phys;
    wire ccWrite = memWe && sel_reg == SEL_CC;
    wire [7:0] wrByte = hwdata[7:0];
    wire [15:0] fileId = `NDEF_FILE_ID;
    wire fidHiOk = wrByte == fileId[15:8];
    wire fidLoOk = wrByte == fileId[7:0];
    wire [31:0] statusWord = {7'h00, curMap.phys, 12'h000, sel_reg != SEL_NONE,
        fidHi_reg && fidLo_reg, verOk_reg, err_reg};

    // bus sequencing: reads hold hready low for two cycles
    always_comb begin
        state_next = state_reg;
        phase_next = phase_reg;
        case (state_reg)
            BUS_IDLE: begin
                phase_next = takeXfer ? takenPhase : '0;
                if (takeXfer && !hwrite) begin
                    state_next = BUS_READ_MEM;
                end
            end
            BUS_READ_MEM: state_next = BUS_READ_OUT;
            BUS_READ_OUT: begin
                state_next = BUS_IDLE;
                phase_next = '0;
            end
            default: state_next = BUS_IDLE;
        endcase
    end

    // selection and file address
    always_comb begin
        sel_next = sel_reg;
        fileAddr_next = fileAddr_reg;
        if (wrSelect && !selRefused) begin
            case (selCode)
                `SEL_CODE_APP: sel_next = SEL_APP; // [R01]
                `SEL_CODE_CC: sel_next = SEL_CC; // [R01]
                `SEL_CODE_NDEF: sel_next = SEL_NDEF; // [R01]
                default: sel_next = SEL_NONE;
            endcase
            fileAddr_next = `RESET_FILE_ADDR;
        end else if (wrFileAddr) begin
            fileAddr_next = hwdata[15:0];
        end else if (dataAccess && curMap.inRange) begin
            fileAddr_next = 16'(fileAddr_reg + 16'h0001); // [R06]
        end
    end

    // an error raised in the clearing cycle survives the clear
    assign err_next = (dataAccess && !curMap.inRange) || selRefused || // [R13]
        (err_reg && !(wrStatus && hwdata[`ST_ERR_BIT]));

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= BUS_IDLE;
            phase_reg <= '0;
            sel_reg <= SEL_NONE;
            fileAddr_reg <= `RESET_FILE_ADDR;
            err_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            sel_reg <= sel_next;
            fileAddr_reg <= fileAddr_next;
            err_reg <= err_next;
        end
    end

    // tracks the capability file's version and identifier bytes as written
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            verOk_reg <= 1'b0;
            fidHi_reg <= 1'b0;
            fidLo_reg <= 1'b0;
        end else if (ccWrite) begin
            if (fileAddr_reg == `CC_VERSION_OFS) begin
                verOk_reg <= wrByte == `CC_VERSION_VALUE; // [R07] [R09]
            end
            if (fileAddr_reg == `CC_TLV_V_OFS) begin
                fidHi_reg <= fidHiOk; // [R08] [R09]
            end
            if (fileAddr_reg == `CC_FID_LO_OFS) begin
                fidLo_reg <= fidLoOk; // [R08]
            end
        end
    end

    logic [31:0] readMux;
    always_comb begin
        case (phase_reg.offset)
            `REG_SELECT: readMux = {30'h0000_0000, selToCode(sel_reg)};
            `REG_FILE_ADDR: readMux = {16'h0000, fileAddr_reg};
            `REG_DATA: readMux = {24'h00_0000, memRdata};
            `REG_STATUS: readMux = statusWord;
            default: readMux = `RESET_WORD;
        endcase
    end

    // no interrupt output exists; only the bus answer leaves the block [R11]
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hreadyout <= 1'b1;
            hrdata <= `RESET_WORD;
            hresp <= `RESP_OKAY;
        end else begin
            hreadyout <= state_next == BUS_IDLE;
            hrdata <= (state_reg == BUS_READ_OUT) ? readMux : hrdata;
            hresp <= `RESP_OKAY;
        end
    end

    nvm_byte_store #(
        .WIDTH(8),
        .DEPTH(DEPTH)
    ) store (
        .clk(ref_clk),
        .reset_n(reset_n),
        .writeEn(memWe),
        .readEn(memRe),
        .addr(memAddr),
        .writeData(wrByte),
        .readData(memRdata)
    );

    property p_sel_gate;
        @(posedge ref_clk) disable iff (!reset_n)
        (sel_reg == SEL_NONE || sel_reg == SEL_APP) |-> !memAccess;
    endproperty
    a_sel_gate: assert property (p_sel_gate) else $error("memory touched without file selected"); // [R01]

    property p_cc_map;
        @(posedge ref_clk) disable iff (!reset_n)
        (memAccess && sel_reg == SEL_CC) |-> memAddr == `CC_PHYS_BASE + fileAddr_reg[PHYS_W-1:0];
    endproperty
    a_cc_map: assert property (p_cc_map) else $error("capability file mapped wrong"); // [R02]

    property p_len_field_map;
        @(posedge ref_clk) disable iff (!reset_n)
        (memAccess && sel_reg == SEL_NDEF && fileAddr_reg < `MSG_FILE_ADDR)
            |-> memAddr == `LEN_FIELD_PHYS_BASE + fileAddr_reg[PHYS_W-1:0];
    endproperty
    a_len_field_map: assert property (p_len_field_map) else $error("length field mapped wrong"); // [R03]

    property p_msg_map;
        @(posedge ref_clk) disable iff (!reset_n)
        (memAccess && sel_reg == SEL_NDEF && fileAddr_reg >= `MSG_FILE_ADDR)
            |-> memAddr == 9'(fileAddr_reg[PHYS_W-1:0] + `MSG_PHYS_BASE - `MSG_FILE_ADDR);
    endproperty
    a_msg_map: assert property (p_msg_map) else $error("message mapped wrong"); // [R04]

    property p_gap_skip;
        @(posedge ref_clk) disable iff (!reset_n)
        (memAccess && sel_reg == SEL_NDEF) |-> memAddr != `GAP_FIRST && memAddr != `GAP_LAST;
    endproperty
    a_gap_skip: assert property (p_gap_skip) else $error("gap byte touched"); // [R05]

    property p_contig;
        @(posedge ref_clk) disable iff (!reset_n)
        (dataAccess && curMap.inRange) |=> fileAddr_reg == 16'($past(fileAddr_reg) + 16'h0001);
    endproperty
    a_contig: assert property (p_contig) else $error("file address did not advance"); // [R06]

    property p_ndef_area;
        @(posedge ref_clk) disable iff (!reset_n)
        (memAccess && sel_reg == SEL_NDEF) |-> memAddr >= `LEN_FIELD_PHYS_BASE && memAddr < `CC_PHYS_BASE;
    endproperty
    a_ndef_area: assert property (p_ndef_area) else $error("message file left its blocks"); // [R12]

    property p_range;
        @(posedge ref_clk) disable iff (!reset_n)
        (dataAccess && !curMap.inRange) |-> !memAccess ##1 err_reg;
    endproperty
    a_range: assert property (p_range) else $error("out of range access not refused"); // [R13]

    sequence s_readTaken;
        state_reg == BUS_IDLE && takeXfer && !hwrite;
    endsequence
    sequence s_readAnswer;
        !hreadyout ##1 !hreadyout ##1 hreadyout;
    endsequence
    property p_read_wait;
        @(posedge ref_clk) disable iff (!reset_n)
        s_readTaken |=> s_readAnswer;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read answer timing wrong"); // [R06]
endmodule // ndef_file_address_mapper

// ---- tb/rf_reader_model.sv ----
`timescale 1ns/1ps
module rf_reader_model (
    // clock
    input wire logic ref_clk,
    // bus answer
    input wire logic hready,
    // bus request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic readPhase
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        readPhase = 1'b0;
    end

    // one single word transfer: address held until hready, then data phase until hready
    task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wdata);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, ofs};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wdata;
        readPhase <= !wr;
        do @(posedge ref_clk); while (hready !== 1'b1);
        readPhase <= 1'b0;
        // released data lines do not keep the old value
        hwdata <= ~wdata;
    endtask
endmodule // rf_reader_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`include "ndef_mapper_map.svh"
module tb_top;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, readPhase;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] expQ[$];
    logic [31:0] maskQ[$];
    int fail_count = 0;
    int n_checks = 0;
    logic [7:0] ccImage [15] = '{8'h00, 8'h0F, 8'h20, 8'h00, 8'h3B, 8'h00, 8'h34, 8'h04, 8'h06, 8'h01,
        8'h03, 8'h00, 8'h32, 8'h00, 8'h00};
    logic [7:0] ndefImage [5] = '{8'h00, 8'h03, 8'hD0, 8'h00, 8'h00};
    logic [15:0] fa;

    always #50 ref_clk = ~ref_clk;

    ndef_file_address_mapper #(.DEPTH(512)) i_ndef_file_address_mapper (.ref_clk(ref_clk), .reset_n(reset_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

    rf_reader_model i_rf_reader_model (.ref_clk(ref_clk), .hready(hreadyout), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .readPhase(readPhase));

    task automatic compare_word(input logic [31:0] got, input logic [31:0] m, input logic [31:0] e);
        n_checks++;
        if ((got & m) !== (e & m) || hresp !== `RESP_OKAY) begin
            fail_count++;
            $display("unexpected at %0t: read %h, wanted %h under mask %h", $time, got, e, m);
        end
    endtask

    // read completes at the edge where the data phase sees hready
    always @(posedge ref_clk) begin
        if (readPhase && hreadyout) begin
            compare_word(hrdata, maskQ.pop_front(), expQ.pop_front());
        end
    end

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        i_rf_reader_model.xfer(1'b1, ofs, d);
    endtask

    task automatic rd(input logic [7:0] ofs, input logic [31:0] m, input logic [31:0] e);
        maskQ.push_back(m);
        expQ.push_back(e);
        i_rf_reader_model.xfer(1'b0, ofs, $urandom);
    endtask

    task automatic wrData(input logic [7:0] b);
        wr(`REG_DATA, ($urandom & 32'hFFFF_FF00) | {24'h0, b});
    endtask

    task automatic chkPhys(input logic [8:0] p);
        rd(`REG_STATUS, 32'h01FF_0000, {7'h0, p, 16'h0});
    endtask

    function automatic logic [8:0] mapNdef(input logic [15:0] a);
        return (a < 16'h2) ? 9'h00C + a[8:0] : 9'h010 + a[8:0] - 9'h002;
    endfunction

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        fail_count++;
        $display("unexpected at %0t: run did not finish", $time);
        print_verdict;
    end

    initial begin
        void'($urandom(42237));
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(`REG_STATUS, 32'h0000_000F, `RESET_WORD);
        rd(`REG_SELECT, 32'h0000_0003, {30'h0, `SEL_CODE_NONE});
        wr(`REG_SELECT, {30'h0, `SEL_CODE_CC});
        rd(`REG_STATUS, 32'h0000_0009, 32'h0000_0001);
        wr(`REG_STATUS, 32'h0000_0001);
        wrData(8'h55);
        rd(`REG_STATUS, 32'h0000_0009, 32'h0000_0001);
        wr(`REG_STATUS, 32'h0000_0001);
        wr(`REG_SELECT, {30'h0, `SEL_CODE_APP});
        wr(`REG_SELECT, {30'h0, `SEL_CODE_CC});
        rd(`REG_SELECT, 32'h0000_0003, {30'h0, `SEL_CODE_CC});
        rd(`REG_STATUS, 32'h0000_0009, 32'h0000_0008);
        for (int i = 0; i < 15; i++) begin
            chkPhys(9'h180 + 9'(i));
            wrData(ccImage[i]);
        end
        rd(`REG_STATUS, 32'h0000_0007, 32'h0000_0006);
        wr(`REG_FILE_ADDR, 32'h0000_0010);
        wrData(8'hA5);
        rd(`REG_STATUS, 32'h0000_0001, 32'h0000_0001);
        rd(`REG_FILE_ADDR, 32'h0000_FFFF, 32'h0000_0010);
        wr(`REG_STATUS, 32'h0000_0001);
        wr(`REG_FILE_ADDR, 32'h0000_0000);
        for (int i = 0; i < 15; i++) rd(`REG_DATA, 32'h0000_00FF, {24'h0, ccImage[i]});
        wr(`REG_SELECT, {30'h0, `SEL_CODE_NDEF});
        rd(`REG_FILE_ADDR, 32'h0000_FFFF, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            chkPhys(mapNdef(16'(i)));
            wrData(ndefImage[i]);
        end
        wr(`REG_FILE_ADDR, 32'h0000_0000);
        for (int i = 0; i < 5; i++) rd(`REG_DATA, 32'h0000_00FF, {24'h0, ndefImage[i]});
        wr(`REG_FILE_ADDR, 32'h0000_0171);
        chkPhys(9'h17F);
        wrData(8'hA5);
        rd(`REG_STATUS, 32'h0000_0001, 32'h0000_0000);
        rd(`REG_FILE_ADDR, 32'h0000_FFFF, 32'h0000_0172);
        wrData(8'h5A);
        rd(`REG_STATUS, 32'h0000_0001, 32'h0000_0001);
        wr(`REG_STATUS, 32'h0000_0001);
        wr(`REG_SELECT, {30'h0, `SEL_CODE_CC});
        rd(`REG_DATA, 32'h0000_00FF, {24'h0, ccImage[0]});
        wr(`REG_SELECT, {30'h0, `SEL_CODE_NDEF});
        repeat (8) begin
            fa = 16'($urandom_range(32'h171, 0));
            wr(`REG_FILE_ADDR, {16'h0, fa});
            chkPhys(mapNdef(fa));
        end
        wr(`REG_SELECT, {30'h0, `SEL_CODE_NONE});
        rd(`REG_SELECT, 32'h0000_0003, {30'h0, `SEL_CODE_NONE});
        rd(`REG_STATUS, 32'h0000_0009, 32'h0000_0000);
        wrData(8'h11);
        rd(`REG_STATUS, 32'h0000_0009, 32'h0000_0001);
        wr(`REG_STATUS, 32'h0000_0001);
        wr(8'h10, $urandom);
        rd(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
        repeat (2) @(posedge ref_clk);
        if (expQ.size() != 0) begin
            fail_count++;
            $display("unexpected at %0t: reads left unanswered", $time);
        end
        print_verdict;
    end
endmodule // tb_top
